// File: logic/dcpuc_dac_end.sv
// DAC end: chained shift register, command execution, power state
`timescale 1ns/1ps
`default_nettype none

module dcpuc_dac_end
	import dcpuc_pkg::*;
#(
	parameter int WAKE_5V_CYC = DCPUC_WAKE_5V_CYCLES,
	parameter int WAKE_3V_CYC = DCPUC_WAKE_3V_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	dcpuc_link_if.dev_mp link,
	input wire logic supply_3v_in,
	output logic [15:0] input_code_out,
	output logic [15:0] dac_code_out,
	output logic powered_down_out,
	output logic settling_out,
	output logic command_done_out
);

	// Link domain, clocked by the shift clock
	logic lrst_s1_reg;
	logic lrst_s2_reg;
	logic [31:0] shift_reg;
	logic [31:0] shift_next;
	logic chain_out_reg;
	logic chain_out_next;

	// Control domain
	logic strb_s1_reg;
	logic strb_s2_reg;
	logic strb_s3_reg;
	logic upd_s1_reg;
	logic upd_s2_reg;
	logic [15:0] input_reg;
	logic [15:0] input_next;
	logic [15:0] dac_reg;
	logic [15:0] dac_next;
	logic pd_reg;
	logic pd_next;
	logic [DCPUC_WAKE_W-1:0] wake_cnt_reg;
	logic [DCPUC_WAKE_W-1:0] wake_cnt_next;
	logic done_reg;
	logic done_next;

	logic strobe_rise;
	logic update_low;
	logic [3:0] cmd;
	logic [15:0] data_field;
	logic do_update;
	logic pd_request;
	logic wake;
	logic [DCPUC_WAKE_W-1:0] wake_load;

	// Link reset acts only on sck edges, and the host stops sck in reset.
	// Stale shift bits are harmless: every command word overwrites them.
	always_ff @(posedge link.sck) begin
		lrst_s1_reg <= rst_n_in;
		lrst_s2_reg <= lrst_s1_reg;
	end

	// Shift only while the strobe is low; the strobe and serial data
	// are launched by the host on the falling edge, so they are
	// already in this domain
	always_comb begin
		shift_next = shift_reg;
		if (!lrst_s2_reg) begin
			shift_next = DCPUC_SHIFT_RESET;
		end else if (!link.select_load_strobe_n) begin
			shift_next = {shift_reg[30:0], link.serial_in};
		end
	end

	always_ff @(posedge link.sck) begin
		shift_reg <= shift_next;
	end

	// Oldest bit leaves on the falling edge after its 32nd rise
	always_comb begin
		chain_out_next = 1'b0;
		if (lrst_s2_reg) begin
			chain_out_next = shift_reg[DCPUC_SHIFT_BITS-1];
		end
	end

	always_ff @(negedge link.sck) begin
		chain_out_reg <= chain_out_next;
	end

	assign link.serial_chain_out = chain_out_reg;

	// Strobe and update pins into the control clock
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			strb_s1_reg <= 1'b1;
			strb_s2_reg <= 1'b1;
			strb_s3_reg <= 1'b1;
			upd_s1_reg <= 1'b1;
			upd_s2_reg <= 1'b1;
		end else begin
			strb_s1_reg <= link.select_load_strobe_n;
			strb_s2_reg <= strb_s1_reg;
			strb_s3_reg <= strb_s2_reg;
			upd_s1_reg <= link.async_update_n;
			upd_s2_reg <= upd_s1_reg;
		end
	end

	assign strobe_rise = strb_s2_reg && !strb_s3_reg;
	assign update_low = !upd_s2_reg;

	// Word is quasi-static here: the strobe is high, so no shift edge
	// touches it until the host lowers the strobe again
	assign cmd = shift_reg[DCPUC_CMD_MSB:DCPUC_CMD_LSB];
	// Narrower variants leave trailing padding in the low bits
	assign data_field = shift_reg[DCPUC_DATA_MSB:0];

	always_comb begin
		wake_load = DCPUC_WAKE_W'(WAKE_5V_CYC);
		if (supply_3v_in) begin
			wake_load = DCPUC_WAKE_W'(WAKE_3V_CYC);
		end
	end

	always_comb begin
		input_next = input_reg;
		dac_next = dac_reg;
		pd_next = pd_reg;
		done_next = 1'b0;
		do_update = 1'b0;
		pd_request = 1'b0;
		wake = update_low;
		wake_cnt_next = wake_cnt_reg;
		if (wake_cnt_reg != '0) begin
			wake_cnt_next = wake_cnt_reg - DCPUC_WAKE_W'(1);
		end
		if (strobe_rise) begin
			done_next = 1'b1;
			case (cmd)
				DCPUC_CMD_WRITE: begin
					input_next = data_field;
				end
				DCPUC_CMD_UPDATE: begin
					do_update = 1'b1;
				end
				DCPUC_CMD_WRITE_UPDATE: begin
					input_next = data_field;
					do_update = 1'b1;
				end
				DCPUC_CMD_POWER_DOWN: begin
					pd_request = !update_low;
				end
				DCPUC_CMD_NOP: begin
				end
				default: begin
				end
			endcase
			// Command and late update meet in one copy
			if (do_update || update_low) begin
				dac_next = input_next;
				wake = 1'b1;
			end
		end else if (strb_s2_reg && update_low) begin
			dac_next = input_reg;
		end
		if (pd_request) begin
			pd_next = 1'b1;
		end else if (wake && pd_reg) begin
			pd_next = 1'b0;
			wake_cnt_next = wake_load;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			input_reg <= DCPUC_CODE_RESET;
			dac_reg <= DCPUC_CODE_RESET;
			pd_reg <= 1'b0;
			wake_cnt_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			input_reg <= input_next;
			dac_reg <= dac_next;
			pd_reg <= pd_next;
			wake_cnt_reg <= wake_cnt_next;
			done_reg <= done_next;
		end
	end

	assign input_code_out = input_reg;
	assign dac_code_out = dac_reg;
	assign powered_down_out = pd_reg;
	assign settling_out = wake_cnt_reg != '0;
	assign command_done_out = done_reg;

endmodule : dcpuc_dac_end
`default_nettype wire

// File: logic/dcpuc_host_end.sv
// Host end: shift clock divider and framed serial master
`timescale 1ns/1ps
`default_nettype none
module dcpuc_host_end
	import dcpuc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	dcpuc_link_if.host_mp link,
	input wire logic frame_valid_in,
	output logic frame_ready_out,
	input wire logic [DCPUC_FRAME_BITS-1:0] frame_in,
	input wire logic update_req_in,
	output logic [DCPUC_FRAME_BITS-1:0] readback_out,
	output logic busy_out
);

	dcpuc_host_state_t state_reg;
	dcpuc_host_state_t state_next;
	logic [1:0] div_reg;
	logic [1:0] div_next;
	logic sck_reg;
	logic sck_next;
	logic [DCPUC_FRAME_BITS-1:0] frame_reg;
	logic [DCPUC_FRAME_BITS-1:0] frame_next;
	logic [DCPUC_FRAME_BITS-1:0] rb_reg;
	logic [DCPUC_FRAME_BITS-1:0] rb_next;
	logic [DCPUC_BITCNT_W-1:0] bit_cnt_reg;
	logic [DCPUC_BITCNT_W-1:0] bit_cnt_next;
	logic [2:0] gap_reg;
	logic [2:0] gap_next;
	logic strobe_n_reg;
	logic strobe_n_next;
	logic sdi_reg;
	logic sdi_next;
	logic upd_n_reg;
	logic sdo_s1_reg;
	logic sdo_s2_reg;
	logic edge_now;
	logic rise;
	logic fall;

	assign edge_now = div_reg == DCPUC_SCK_HALF_LAST;
	assign rise = edge_now && !sck_reg;
	assign fall = edge_now && sck_reg;
	assign frame_ready_out = (state_reg == DCPUC_IDLE) && fall;

	// Free-running outside reset, so the far end sees edges between frames
	always_comb begin
		div_next = edge_now ? 2'h0 : div_reg + 2'h1;
		sck_next = edge_now ? !sck_reg : sck_reg;
	end

	always_comb begin
		state_next = state_reg;
		frame_next = frame_reg;
		rb_next = rb_reg;
		bit_cnt_next = bit_cnt_reg;
		gap_next = gap_reg;
		strobe_n_next = strobe_n_reg;
		sdi_next = sdi_reg;
		case (state_reg)
			DCPUC_IDLE: begin
				if (frame_valid_in && fall) begin
					// Caller orders words farthest device first
					frame_next = {frame_in[DCPUC_FRAME_BITS-2:0], 1'b0};
					sdi_next = frame_in[DCPUC_FRAME_BITS-1];
					strobe_n_next = 1'b0;
					bit_cnt_next = DCPUC_BITCNT_W'(DCPUC_FRAME_BITS);
					state_next = DCPUC_SHIFT;
				end
			end
			DCPUC_SHIFT: begin
				if (rise) begin
					rb_next = {rb_reg[DCPUC_FRAME_BITS-2:0], sdo_s2_reg};
					bit_cnt_next = bit_cnt_reg - DCPUC_BITCNT_W'(1);
					if (bit_cnt_reg == DCPUC_BITCNT_W'(1)) begin
						state_next = DCPUC_FINISH;
					end
				end else if (fall) begin
					sdi_next = frame_reg[DCPUC_FRAME_BITS-1];
					frame_next = {frame_reg[DCPUC_FRAME_BITS-2:0], 1'b0};
				end
			end
			DCPUC_FINISH: begin
				if (fall) begin
					strobe_n_next = 1'b1;
					gap_next = DCPUC_GAP_HALVES;
					state_next = DCPUC_GAP;
				end
			end
			DCPUC_GAP: begin
				if (fall) begin
					gap_next = gap_reg - 3'h1;
					if (gap_reg == 3'h1) begin
						state_next = DCPUC_IDLE;
					end
				end
			end
			default: begin
				state_next = DCPUC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_reg <= DCPUC_IDLE;
			div_reg <= 2'h0;
			sck_reg <= 1'b0;
			frame_reg <= '0;
			rb_reg <= '0;
			bit_cnt_reg <= '0;
			gap_reg <= 3'h0;
			strobe_n_reg <= 1'b1;
			sdi_reg <= 1'b0;
			upd_n_reg <= 1'b1;
			sdo_s1_reg <= 1'b0;
			sdo_s2_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			div_reg <= div_next;
			sck_reg <= sck_next;
			frame_reg <= frame_next;
			rb_reg <= rb_next;
			bit_cnt_reg <= bit_cnt_next;
			gap_reg <= gap_next;
			strobe_n_reg <= strobe_n_next;
			sdi_reg <= sdi_next;
			upd_n_reg <= !update_req_in;
			sdo_s1_reg <= link.serial_chain_out;
			sdo_s2_reg <= sdo_s1_reg;
		end
	end

	assign link.sck = sck_reg;
	assign link.select_load_strobe_n = strobe_n_reg;
	assign link.serial_in = sdi_reg;
	assign link.async_update_n = upd_n_reg;
	assign readback_out = rb_reg;
	assign busy_out = state_reg != DCPUC_IDLE;

endmodule : dcpuc_host_end
`default_nettype wire

// File: logic/dcpuc_link_if.sv
// Serial link between the host master and the DAC control end
`timescale 1ns/1ps
`default_nettype none
interface dcpuc_link_if;
	logic sck;
	logic select_load_strobe_n;
	logic serial_in;
	logic serial_chain_out;
	logic async_update_n;

	modport host_mp (
		output sck,
		output select_load_strobe_n,
		output serial_in,
		output async_update_n,
		input serial_chain_out
	);

	modport dev_mp (
		input sck,
		input select_load_strobe_n,
		input serial_in,
		input async_update_n,
		output serial_chain_out
	);
endinterface : dcpuc_link_if
`default_nettype wire

// File: logic/dcpuc_pkg.sv
// Shared constants and types for the serial DAC control link
package dcpuc_pkg;

	// Word layout
	localparam int DCPUC_WORD_BITS = 24;
	localparam int DCPUC_EXT_BITS = 32;
	localparam int DCPUC_SHIFT_BITS = 32;
	localparam int DCPUC_DATA_BITS = 16;
	localparam int DCPUC_CMD_MSB = 23;
	localparam int DCPUC_CMD_LSB = 20;
	localparam int DCPUC_DATA_MSB = 15;

	// Command codes
	localparam logic [3:0] DCPUC_CMD_WRITE = 4'h0;
	localparam logic [3:0] DCPUC_CMD_UPDATE = 4'h1;
	localparam logic [3:0] DCPUC_CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] DCPUC_CMD_POWER_DOWN = 4'h4;
	localparam logic [3:0] DCPUC_CMD_NOP = 4'hF;

	// Values after reset
	localparam logic [15:0] DCPUC_CODE_RESET = 16'h0000;
	localparam logic [31:0] DCPUC_SHIFT_RESET = 32'h0000_0000;

	// Power-up delay, given in microseconds and scaled to clk_in cycles
	localparam int DCPUC_CLK_MHZ = 200;
	localparam int DCPUC_WAKE_5V_US = 12;
	localparam int DCPUC_WAKE_3V_US = 30;
	localparam int DCPUC_WAKE_5V_CYCLES = DCPUC_WAKE_5V_US * DCPUC_CLK_MHZ;
	localparam int DCPUC_WAKE_3V_CYCLES = DCPUC_WAKE_3V_US * DCPUC_CLK_MHZ;
	localparam int DCPUC_WAKE_W = 13;

	// Host side framing and shift clock divider
	localparam int DCPUC_CHAIN_DEVICES = 2;
	localparam int DCPUC_FRAME_BITS = DCPUC_EXT_BITS * DCPUC_CHAIN_DEVICES;
	localparam int DCPUC_BITCNT_W = 7;
	localparam logic [1:0] DCPUC_SCK_HALF_LAST = 2'h2;
	localparam logic [2:0] DCPUC_GAP_HALVES = 3'h4;

	typedef enum logic [1:0] {
		DCPUC_IDLE,
		DCPUC_SHIFT,
		DCPUC_FINISH,
		DCPUC_GAP
	} dcpuc_host_state_t;

endpackage : dcpuc_pkg

// File: tb/dcpuc_link_chk.sv
// Assertions on the link between host and DAC ends
`timescale 1ns/1ps
`default_nettype none
module dcpuc_link_chk (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sck,
	input wire logic select_load_strobe_n,
	input wire logic serial_in,
	input wire logic serial_chain_out,
	input wire logic async_update_n
);
	logic sck_d_reg;
	logic rise;
	logic [6:0] cnt_reg, cnt_next;
	logic [31:0] hist_reg, hist_next;
	logic [5:0] fill_reg, fill_next;

	// Sck is derived from clk_in, so its edges are seen on clk_in
	always_comb begin
		rise = sck && !sck_d_reg;
		cnt_next = select_load_strobe_n ? 7'h00 : cnt_reg + {6'h00, rise};
		hist_next = hist_reg;
		fill_next = fill_reg;
		if (rise && !select_load_strobe_n) begin
			hist_next = {hist_reg[30:0], serial_in};
			fill_next = (fill_reg == 6'h20) ? fill_reg : fill_reg + 6'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sck_d_reg <= 1'h0;
			cnt_reg <= 7'h00;
			hist_reg <= 32'h0000_0000;
			fill_reg <= 6'h00;
		end else begin
			sck_d_reg <= sck;
			cnt_reg <= cnt_next;
			hist_reg <= hist_next;
			fill_reg <= fill_next;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_high_half;
		sck [*2] ##1 !sck;
	endsequence
	sequence s_low_half;
		!sck [*2] ##1 sck;
	endsequence
	property p_sck_high;
		$rose(sck) |=> s_high_half;
	endproperty
	property p_sck_low;
		$fell(sck) |=> s_low_half;
	endproperty
	property p_data_stable;
		sck |-> $stable(serial_in);
	endproperty
	property p_setup;
		$fell(select_load_strobe_n) |-> !sck;
	endproperty
	property p_end_low;
		$rose(select_load_strobe_n) |-> !sck;
	endproperty
	property p_gap;
		$rose(select_load_strobe_n) |-> select_load_strobe_n [*8];
	endproperty
	property p_frame_len;
		$rose(select_load_strobe_n) |-> cnt_reg == 7'h40;
	endproperty
	// Bit from 32 rises back leaves at the fall after the latest rise
	property p_chain_delay;
		(!sck && sck_d_reg && fill_reg == 6'h20) |->
			serial_chain_out == hist_reg[31];
	endproperty

	a_sck_high: assert property (p_sck_high)
		else $error("sck high phase wrong");
	a_sck_low: assert property (p_sck_low)
		else $error("sck low phase wrong");
	a_data_stable: assert property (p_data_stable)
		else $error("serial_in moved while sck high");
	a_setup: assert property (p_setup)
		else $error("strobe fell with sck high");
	a_end_low: assert property (p_end_low)
		else $error("strobe rose with sck high");
	a_gap: assert property (p_gap)
		else $error("strobe gap too short");
	a_frame_len: assert property (p_frame_len)
		else $error("frame length not 64");
	a_chain_delay: assert property (p_chain_delay)
		else $error("chain output delay wrong");
endmodule : dcpuc_link_chk
`default_nettype wire

// File: tb/tb.sv
// Bench joining the host and DAC ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dcpuc_pkg::*;
	typedef struct packed {
		logic [3:0] cmd;
		logic [15:0] data, ei, ed;
		logic pd;
	} dcpuc_row_t;
	logic clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic frame_valid_in = 1'h0;
	logic [63:0] frame_in = 64'h0;
	logic update_req_in = 1'h0;
	logic supply_3v_in = 1'h0;
	logic frame_ready_out, busy_out, powered_down_out, settling_out;
	logic command_done_out;
	logic [15:0] input_code_out, dac_code_out;
	logic [63:0] readback_out;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_done = 0;
	dcpuc_row_t rows [10] = '{
		'{4'h0, 16'h1234, 16'h1234, 16'h0000, 1'h0},
		'{4'h1, 16'hFFFF, 16'h1234, 16'h1234, 1'h0},
		'{4'h3, 16'hABCD, 16'hABCD, 16'hABCD, 1'h0},
		'{4'h4, 16'h5555, 16'hABCD, 16'hABCD, 1'h1},
		'{4'h0, 16'h0F0F, 16'h0F0F, 16'hABCD, 1'h1},
		'{4'hF, 16'h7777, 16'h0F0F, 16'hABCD, 1'h1},
		'{4'h2, 16'h9999, 16'h0F0F, 16'hABCD, 1'h1},
		'{4'h1, 16'h0000, 16'h0F0F, 16'h0F0F, 1'h0},
		'{4'hE, 16'h1111, 16'h0F0F, 16'h0F0F, 1'h0},
		'{4'h3, 16'h3FF0, 16'h3FF0, 16'h3FF0, 1'h0}
	};

	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) if (command_done_out === 1'h1) n_done++;

	dcpuc_link_if u_dcpuc_link_if ();
	dcpuc_host_end u_dcpuc_host_end (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link(u_dcpuc_link_if.host_mp), .frame_valid_in(frame_valid_in),
		.frame_ready_out(frame_ready_out), .frame_in(frame_in),
		.update_req_in(update_req_in), .readback_out(readback_out),
		.busy_out(busy_out));
	dcpuc_dac_end #(.WAKE_5V_CYC(20), .WAKE_3V_CYC(40)) u_dcpuc_dac_end (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .link(u_dcpuc_link_if.dev_mp),
		.supply_3v_in(supply_3v_in), .input_code_out(input_code_out),
		.dac_code_out(dac_code_out), .powered_down_out(powered_down_out),
		.settling_out(settling_out), .command_done_out(command_done_out));
	dcpuc_link_chk u_dcpuc_link_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.sck(u_dcpuc_link_if.sck),
		.select_load_strobe_n(u_dcpuc_link_if.select_load_strobe_n),
		.serial_in(u_dcpuc_link_if.serial_in),
		.serial_chain_out(u_dcpuc_link_if.serial_chain_out),
		.async_update_n(u_dcpuc_link_if.async_update_n));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic give_up();
		n_mismatch++;
		$display("wrong value at %0t: wait ran out", $time);
		test_done();
	endtask : give_up

	task automatic state(input logic [15:0] ei, ed, input logic ep);
		check(input_code_out, ei);
		check(dac_code_out, ed);
		check({15'h0000, powered_down_out}, {15'h0000, ep});
	endtask : state

	// Far word is a no-operation so only the near device acts
	task automatic start(input logic [3:0] cmd, input logic [15:0] data);
		int i;
		@(posedge clk_in);
		frame_in <= {8'h00, DCPUC_CMD_NOP, 20'h0_0000,
			8'h00, cmd, 4'h0, data};
		frame_valid_in <= 1'h1;
		for (i = 0; i < 40; i++) begin
			@(negedge clk_in);
			if (frame_ready_out === 1'h1) break;
		end
		if (i == 40) give_up();
		@(posedge clk_in);
		frame_valid_in <= 1'h0;
	endtask : start

	task automatic end_frame();
		int i;
		for (i = 0; i < 1000; i++) begin
			@(negedge clk_in);
			if (busy_out === 1'h0) break;
		end
		if (i == 1000) give_up();
		repeat (4) @(negedge clk_in);
	endtask : end_frame

	task automatic send(input logic [3:0] cmd, input logic [15:0] data);
		start(cmd, data);
		end_frame();
	endtask : send

	// Eleven edges low; sck stops, so link side keeps stale bits
	task automatic do_reset();
		@(posedge clk_in);
		rst_n_in <= 1'h0;
		repeat (10) @(posedge clk_in);
		@(negedge clk_in);
		state(16'h0000, 16'h0000, 1'h0);
		check({15'h0000, u_dcpuc_link_if.select_load_strobe_n}, 16'h0001);
		@(posedge clk_in);
		rst_n_in <= 1'h1;
	endtask : do_reset

	initial begin
		int d0, w;
		do_reset();
		foreach (rows[k]) begin
			d0 = n_done;
			send(rows[k].cmd, rows[k].data);
			state(rows[k].ei, rows[k].ed, rows[k].pd);
			check(16'(n_done - d0), 16'h0001);
			// Old word comes back ahead of this frame's far word
			if (k > 0) begin
				check(readback_out[47:32], rows[k-1].data);
				check(readback_out[31:16], 16'h00F0);
			end
		end
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_in);
			supply_3v_in <= s[0];
			send(DCPUC_CMD_WRITE, 16'h2222 + 16'(s));
			send(DCPUC_CMD_POWER_DOWN, 16'h0000);
			@(posedge clk_in);
			update_req_in <= 1'h1;
			w = 0;
			repeat (100) begin
				@(negedge clk_in);
				if (settling_out === 1'h1) w++;
			end
			check(16'(w), s ? 16'h0028 : 16'h0014);
			@(posedge clk_in);
			update_req_in <= 1'h0;
			@(negedge clk_in);
			state(16'h2222 + 16'(s), 16'h2222 + 16'(s), 1'h0);
		end
		send(DCPUC_CMD_POWER_DOWN, 16'h0000);
		start(DCPUC_CMD_WRITE, 16'h6666);
		repeat (60) @(posedge clk_in);
		update_req_in <= 1'h1;
		repeat (8) @(posedge clk_in);
		update_req_in <= 1'h0;
		end_frame();
		state(16'h6666, 16'h2223, 1'h0);
		@(posedge clk_in);
		update_req_in <= 1'h1;
		send(DCPUC_CMD_POWER_DOWN, 16'h0000);
		state(16'h6666, 16'h6666, 1'h0);
		start(DCPUC_CMD_WRITE, 16'h4321);
		for (w = 0; w < 1000; w++) begin
			@(negedge clk_in);
			if (command_done_out === 1'h1) break;
		end
		if (w == 1000) give_up();
		check(dac_code_out, 16'h4321);
		end_frame();
		state(16'h4321, 16'h4321, 1'h0);
		@(posedge clk_in);
		update_req_in <= 1'h0;
		start(DCPUC_CMD_WRITE, 16'h7777);
		repeat (100) @(posedge clk_in);
		do_reset();
		send(DCPUC_CMD_WRITE_UPDATE, 16'h0001);
		state(16'h0001, 16'h0001, 1'h0);
		test_done();
	end
endmodule : tb
`default_nettype wire
